// ### core/pus_pkg.sv
// Shared constants, types and helpers of the position unit scaling block.
package pus_pkg;

    // ----------------------------------------------------------------
    // Parameter addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] PUS_ADDR_DEN   = 16'h060E;
    localparam logic [15:0] PUS_ADDR_NUM   = 16'h0610;
    localparam logic [31:0] PUS_RST_DEN    = 32'h0000_4000;
    localparam logic [31:0] PUS_RST_NUM    = 32'h0000_0001;
    localparam logic [31:0] PUS_VAL_MIN    = 32'h0000_0001;
    localparam logic [31:0] PUS_VAL_MAX    = 32'h7FFF_FFFF;

    // ----------------------------------------------------------------
    // Motor resolution and working range
    // ----------------------------------------------------------------
    localparam int          PUS_RES_SHIFT  = 15;
    localparam logic [31:0] PUS_RES_INCR   = 32'h0000_8000;
    localparam int          PUS_LIM_SHIFT  = 17;

    // ----------------------------------------------------------------
    // Arithmetic widths and value store
    // ----------------------------------------------------------------
    localparam int          PUS_MUL_W      = 46;
    localparam int          PUS_PROD_W     = 78;
    localparam logic [6:0]  PUS_DIV_STEPS  = 7'h4E;
    localparam int          PUS_SLOTS      = 8;
    localparam logic [2:0]  PUS_LAST_SLOT  = 3'h7;

    typedef enum logic [2:0] {
        PUS_IDLE  = 3'b000,
        PUS_FETCH = 3'b001,
        PUS_LOAD  = 3'b011,
        PUS_CALC  = 3'b010,
        PUS_STORE = 3'b110,
        PUS_EXT   = 3'b100
    } pus_state_t;

    // Legal numerator or denominator value.
    function automatic logic pus_in_range(input logic [31:0] v);
        return (v >= PUS_VAL_MIN) && (v <= PUS_VAL_MAX);
    endfunction

endpackage

// ### core/pus_conv_if.sv
// Request and answer signals between the scaling controller and its divider.
`timescale 1ns/10ps
`default_nettype none
interface pus_conv_if;
    logic                 start;
    logic signed [31:0]   val;
    logic [45:0]          mul;
    logic [45:0]          divs;
    logic                 done;
    logic [31:0]          result;
    logic                 ovf;

    modport ctrl (output start, output val, output mul, output divs, input done, input result, input ovf);
    modport conv (input start, input val, input mul, input divs, output done, output result, output ovf);
endinterface
`default_nettype wire

// ### core/pus_mem.sv
// Small value store with registered read data.
`timescale 1ns/10ps
`default_nettype none
module pus_mem
    import pus_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // Write port.
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [31:0] wdata,
    // Read port.
    input  wire logic [3:0]  raddr,
    output logic      [31:0] rdata_r
);
    logic [31:0] mem [0:2*PUS_SLOTS-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ### core/pus_divider.sv
// Multiply then divide by restoring long division, truncating toward zero.
`timescale 1ns/10ps
`default_nettype none
module pus_divider
    import pus_pkg::*;
(
    // Clock and reset.
    input  wire logic  clk,
    input  wire logic  resetn,
    // Conversion request and answer.
    pus_conv_if.conv   cv
);
    logic [46:0]           rem_r;
    logic [PUS_PROD_W-1:0] quo_r;
    logic [45:0]           divs_r;
    logic [6:0]            cnt_r;
    logic                  busy_r;
    logic                  neg_r;
    logic                  done_r;
    logic [31:0]           result_r;
    logic                  ovf_r;
    logic [31:0]           mag;
    logic [46:0]           trial;

    assign mag   = cv.val[31] ? 32'(-cv.val) : cv.val;
    assign trial = {rem_r[45:0], quo_r[PUS_PROD_W-1]};

    // ----------------------------------------------------------------
    // Division steps
    // ----------------------------------------------------------------
    // One quotient bit per clock keeps the 78-bit datapath small at the cost of latency.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rem_r  <= '0;
            quo_r  <= '0;
            divs_r <= '0;
            cnt_r  <= 7'h00;
            busy_r <= 1'b0;
            neg_r  <= 1'b0;
        end else if (cv.start && !busy_r) begin
            rem_r  <= '0;
            quo_r  <= {46'h0, mag} * {32'h0, cv.mul};
            divs_r <= cv.divs;
            cnt_r  <= PUS_DIV_STEPS;
            busy_r <= 1'b1;
            neg_r  <= cv.val[31];
        end else if (busy_r && cnt_r != 7'h00) begin
            cnt_r <= cnt_r - 7'h01;
            if (trial >= {1'b0, divs_r}) begin
                rem_r <= trial - {1'b0, divs_r};
                quo_r <= {quo_r[PUS_PROD_W-2:0], 1'b1};
            end else begin
                rem_r <= trial;
                quo_r <= {quo_r[PUS_PROD_W-2:0], 1'b0};
            end
        end else if (busy_r) begin
            busy_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Result with range check
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_r   <= 1'b0;
            result_r <= 32'h0000_0000;
            ovf_r    <= 1'b0;
        end else begin
            done_r <= busy_r && cnt_r == 7'h00;
            if (busy_r && cnt_r == 7'h00) begin
                ovf_r <= |quo_r[PUS_PROD_W-1:31];
                if (|quo_r[PUS_PROD_W-1:31]) begin
                    result_r <= neg_r ? 32'h8000_0001 : PUS_VAL_MAX;
                end else begin
                    result_r <= neg_r ? 32'(-{1'b0, quo_r[30:0]}) : {1'b0, quo_r[30:0]};
                end
            end
        end
    end

    assign cv.done   = done_r;
    assign cv.result = result_r;
    assign cv.ovf    = ovf_r;
endmodule
`default_nettype wire

// ### core/pus_top.sv
// Position unit scaling: factor parameters, stored user values and conversions.
//
// What this block does
// - Positions are converted from user units to motor increments and back with one scaling factor.
// - The factor is a ratio of motor revolutions (numerator) over user units (denominator).
// - Position values are kept in user units; internal values are derived copies.
// - A new factor takes effect only when the numerator is written; a denominator write alone waits.
// - A factor below one revolution per 131072 user units narrows the working range and is flagged.
// - A conversion whose result leaves the 32-bit working range raises a sticky range error.
// - The factor can be changed only while the power stage is disabled.
// - Each enabling of the power stage converts all stored user values into internal units.
// - After reset the factor is numerator 1 over denominator 16384.
// - The motor resolution is 32768 increments per revolution.
// - Results that do not fit are limited, which may reduce user limit values.
`timescale 1ns/10ps
`default_nettype none
module pus_top
    import pus_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // Parameter access from the fieldbus.
    input  wire logic [15:0] par_addr,
    input  wire logic        par_wr,
    input  wire logic        par_rd,
    input  wire logic [31:0] par_wdata,
    output logic      [31:0] par_rdata,
    output logic             par_rvalid,
    output logic             par_refused,
    // Power stage state.
    input  wire logic        power_en,
    // Stored user values.
    input  wire logic        usr_wr,
    input  wire logic [2:0]  usr_idx,
    input  wire logic [31:0] usr_wdata,
    output logic             usr_ready,
    input  wire logic        val_rd,
    input  wire logic [3:0]  val_idx,
    output logic             val_ready,
    output logic      [31:0] val_rdata,
    output logic             val_rvalid,
    // On-demand conversion.
    input  wire logic        conv_req,
    input  wire logic        conv_to_usr,
    input  wire logic [31:0] conv_val,
    output logic             conv_ready,
    output logic             conv_done,
    output logic      [31:0] conv_result,
    output logic             conv_ovf,
    // Status.
    input  wire logic        err_clr,
    output logic             range_err,
    output logic             factor_limited,
    output logic             scaled_valid
);
    pus_state_t  state_r;
    pus_state_t  state_nxt;
    logic [2:0]  slot_r;

    logic        power_d_r;
    logic        power_rise;
    logic        rise_pend_r;
    logic        seq_kick;

    logic        last_store;
    logic        ext_take;
    logic        ext_fin;

    logic [31:0] num_r;
    logic [31:0] den_r;
    logic [31:0] act_num_r;
    logic [31:0] act_den_r;
    logic        num_take;
    logic        den_take;

    logic [31:0] par_rdata_r;
    logic        par_rvalid_r;
    logic        par_refused_r;

    logic        range_err_r;
    logic        scaled_valid_r;
    logic        conv_done_r;
    logic [31:0] conv_result_r;
    logic        conv_ovf_r;
    logic        val_rvalid_r;

    logic        mem_we;
    logic [3:0]  mem_waddr;
    logic [31:0] mem_wdata;
    logic [3:0]  mem_raddr;
    logic [31:0] mem_rdata;

    logic        to_usr;
    logic [45:0] rev_term;
    logic [45:0] usr_term;

    pus_conv_if cif ();

    // ----------------------------------------------------------------
    // Scaling factor parameters
    // ----------------------------------------------------------------
    assign num_take = par_wr && par_addr == PUS_ADDR_NUM && pus_in_range(par_wdata)
                      && !power_en && state_r == PUS_IDLE;
    assign den_take = par_wr && par_addr == PUS_ADDR_DEN && pus_in_range(par_wdata);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            num_r     <= PUS_RST_NUM;
            den_r     <= PUS_RST_DEN;
            act_num_r <= PUS_RST_NUM;
            act_den_r <= PUS_RST_DEN;
        end else begin
            if (den_take) begin
                den_r <= par_wdata;
            end
            // A denominator written in the same cycle as the numerator pairs with it.
            if (num_take) begin
                num_r     <= par_wdata;
                act_num_r <= par_wdata;
                act_den_r <= den_take ? par_wdata : den_r;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            par_rdata_r   <= 32'h0000_0000;
            par_rvalid_r  <= 1'b0;
            par_refused_r <= 1'b0;
        end else begin
            par_rvalid_r  <= par_rd;
            par_refused_r <= par_wr && !num_take && !den_take;
            if (par_rd) begin
                unique case (par_addr)
                    PUS_ADDR_NUM: par_rdata_r <= num_r;
                    PUS_ADDR_DEN: par_rdata_r <= den_r;
                    default:      par_rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Numerator times 2^17 against denominator flags a factor below 1/131072.
    assign factor_limited = {act_num_r[30:0], {PUS_LIM_SHIFT{1'b0}}} < {17'h0, act_den_r[30:0]};

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    assign power_rise = power_en && !power_d_r;
    assign seq_kick   = power_rise || (rise_pend_r && power_en);
    assign last_store = state_r == PUS_STORE && slot_r == PUS_LAST_SLOT;
    assign ext_fin    = state_r == PUS_EXT && cif.done;

    // A pending enable goes before an on-demand request.
    assign conv_ready = state_r == PUS_IDLE && !seq_kick;
    assign ext_take   = conv_req && conv_ready;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PUS_IDLE: begin
                if (seq_kick) begin
                    state_nxt = PUS_FETCH;
                end else if (conv_req) begin
                    state_nxt = PUS_EXT;
                end
            end
            PUS_FETCH: state_nxt = PUS_LOAD;
            PUS_LOAD:  state_nxt = PUS_CALC;
            PUS_CALC:  state_nxt = cif.done ? PUS_STORE : PUS_CALC;
            PUS_STORE: state_nxt = last_store ? PUS_IDLE : PUS_FETCH;
            PUS_EXT:   state_nxt = cif.done ? PUS_IDLE : PUS_EXT;
            default:   state_nxt = PUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r   <= PUS_IDLE;
            power_d_r <= 1'b0;
            slot_r    <= 3'h0;
        end else begin
            state_r   <= state_nxt;
            power_d_r <= power_en;
            if (state_r == PUS_IDLE) begin
                slot_r <= 3'h0;
            end else if (state_r == PUS_STORE) begin
                slot_r <= slot_r + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scaled_valid_r <= 1'b0;
        end else if (!power_en || power_rise) begin
            scaled_valid_r <= 1'b0;
        end else if (last_store && !rise_pend_r) begin
            scaled_valid_r <= 1'b1;
        end
    end

    // An enable that lands while the sequencer is busy is kept, so no enabling goes unconverted.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rise_pend_r <= 1'b0;
        end else if (power_rise && state_r != PUS_IDLE) begin
            rise_pend_r <= 1'b1;
        end else if (state_r == PUS_IDLE || !power_en) begin
            rise_pend_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Divider request
    // ----------------------------------------------------------------
    // The divider latches both terms at its start.
    assign to_usr   = (state_r == PUS_IDLE) ? conv_to_usr : 1'b0;
    assign rev_term = {act_num_r[30:0], {PUS_RES_SHIFT{1'b0}}};
    assign usr_term = {15'h0, act_den_r[30:0]};

    assign cif.start = ext_take || state_r == PUS_LOAD;
    assign cif.val   = (state_r == PUS_LOAD) ? mem_rdata : conv_val;
    assign cif.mul   = to_usr ? usr_term : rev_term;
    assign cif.divs  = to_usr ? rev_term : usr_term;

    pus_divider u_div (
        .clk    (clk),
        .resetn (resetn),
        .cv     (cif)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conv_done_r   <= 1'b0;
            conv_result_r <= 32'h0000_0000;
            conv_ovf_r    <= 1'b0;
        end else begin
            conv_done_r <= ext_fin;
            if (ext_fin) begin
                conv_result_r <= cif.result;
                conv_ovf_r    <= cif.ovf;
            end
        end
    end

    // Set wins over a clear in the same cycle so no overflow is missed.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            range_err_r <= 1'b0;
        end else if (cif.done && cif.ovf) begin
            range_err_r <= 1'b1;
        end else if (err_clr) begin
            range_err_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Value store: slots 0-7 user units, 8-15 internal copies
    // ----------------------------------------------------------------
    // The store cycle owns the write port, so user writes wait.
    assign usr_ready = state_r != PUS_STORE;
    assign val_ready = state_r != PUS_FETCH;
    assign mem_we    = state_r == PUS_STORE || usr_wr;
    assign mem_waddr = (state_r == PUS_STORE) ? {1'b1, slot_r} : {1'b0, usr_idx};
    assign mem_wdata = (state_r == PUS_STORE) ? cif.result : usr_wdata;
    assign mem_raddr = (state_r == PUS_FETCH) ? {1'b0, slot_r} : val_idx;

    pus_mem u_mem (
        .clk     (clk),
        .resetn  (resetn),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata_r (mem_rdata)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            val_rvalid_r <= 1'b0;
        end else begin
            val_rvalid_r <= val_rd && val_ready;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign par_rdata    = par_rdata_r;
    assign par_rvalid   = par_rvalid_r;
    assign par_refused  = par_refused_r;
    assign val_rdata    = mem_rdata;
    assign val_rvalid   = val_rvalid_r;
    assign conv_done    = conv_done_r;
    assign conv_result  = conv_result_r;
    assign conv_ovf     = conv_ovf_r;
    assign range_err    = range_err_r;
    assign scaled_valid = scaled_valid_r;
endmodule
`default_nettype wire

// ### testbench/pus_checker.sv
// Concurrent checks on the ports of the position unit scaling block.
`timescale 1ns/10ps
`default_nettype none
module pus_checker
    import pus_pkg::*;
(
    // Clock and reset.
    input wire logic        clk,
    input wire logic        resetn,
    // Parameter port.
    input wire logic [15:0] par_addr,
    input wire logic        par_wr,
    input wire logic        par_rd,
    input wire logic [31:0] par_wdata,
    input wire logic [31:0] par_rdata,
    input wire logic        par_rvalid,
    input wire logic        par_refused,
    // Power and conversion.
    input wire logic        power_en,
    input wire logic        conv_req,
    input wire logic        conv_ready,
    input wire logic        conv_done,
    input wire logic [31:0] conv_result,
    input wire logic        conv_ovf,
    // Status.
    input wire logic        err_clr,
    input wire logic        range_err,
    input wire logic        scaled_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_take;
        conv_req && conv_ready;
    endsequence
    sequence s_ovf_done;
        conv_done && conv_ovf;
    endsequence
    sequence s_power_off;
        !power_en [*2];
    endsequence

    chk_read_answer: assert property (par_rd |=> par_rvalid)
        else $error("parameter read not answered");
    chk_unmapped_zero: assert property (par_rd && par_addr != PUS_ADDR_NUM && par_addr != PUS_ADDR_DEN
        |=> par_rdata == 32'h0) else $error("unmapped read not zero");
    chk_num_powered: assert property (par_wr && par_addr == PUS_ADDR_NUM && power_en |=> par_refused)
        else $error("numerator taken while powered");
    chk_zero_refused: assert property (par_wr && par_wdata == 32'h0 |=> par_refused)
        else $error("zero parameter taken");
    chk_den_taken: assert property (par_wr && par_addr == PUS_ADDR_DEN && par_wdata != 32'h0
        && !par_wdata[31] |=> !par_refused) else $error("legal denominator refused");
    chk_conv_latency: assert property (s_take |-> ##[81:82] conv_done)
        else $error("conversion answer late");
    chk_ovf_sticky: assert property (s_ovf_done |-> range_err)
        else $error("overflow did not raise range error");
    chk_ovf_saturate: assert property (s_ovf_done |-> conv_result == 32'h7FFF_FFFF
        || conv_result == 32'h8000_0001) else $error("overflow result not limited");
    chk_err_holds: assert property (range_err && !err_clr |=> range_err)
        else $error("range error dropped without clear");
    chk_scaled_off: assert property (s_power_off |-> !scaled_valid)
        else $error("scaled values valid while power off");
endmodule
`default_nettype wire

// ### testbench/pus_master_model.sv
// Fieldbus master model that writes and reads the scaling parameters.
`timescale 1ns/10ps
`default_nettype none
module pus_master_model (
    // Clock.
    input wire logic         clk,
    // Parameter port of the block.
    output logic      [15:0] par_addr,
    output logic             par_wr,
    output logic             par_rd,
    output logic      [31:0] par_wdata,
    input  wire logic [31:0] par_rdata,
    input  wire logic        par_rvalid,
    input  wire logic        par_refused
);
    initial begin
        par_addr = 16'h0;
        par_wr = 1'b0;
        par_rd = 1'b0;
        par_wdata = 32'h0;
    end

    // Released data is inverted so that a stale word never looks like a fresh one.
    task automatic put(input logic [15:0] a, input logic [31:0] d, output logic refused);
        @(posedge clk);
        par_wr <= 1'b1;
        par_addr <= a;
        par_wdata <= d;
        @(posedge clk);
        par_wr <= 1'b0;
        par_wdata <= ~d;
        @(posedge clk);
        refused = par_refused;
    endtask

    task automatic get(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        par_rd <= 1'b1;
        par_addr <= a;
        @(posedge clk);
        par_rd <= 1'b0;
        @(posedge clk);
        d = par_rvalid ? par_rdata : ~par_rdata;
    endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking testbench of the position unit scaling block.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import pus_pkg::*;
;
    logic        clk, resetn, power_en, usr_wr, val_rd, conv_req, conv_to_usr, err_clr;
    logic        par_wr, par_rd, par_rvalid, par_refused, usr_ready, val_ready, val_rvalid;
    logic        conv_ready, conv_done, conv_ovf, range_err, factor_limited, scaled_valid;
    logic [2:0]  usr_idx;
    logic [3:0]  val_idx;
    logic [15:0] par_addr;
    logic [31:0] par_wdata, par_rdata, usr_wdata, val_rdata, conv_val, conv_result;
    int          err_count, n_compared, cycles;

    pus_top i_dut (.clk(clk), .resetn(resetn), .par_addr(par_addr), .par_wr(par_wr), .par_rd(par_rd),
        .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rvalid(par_rvalid), .par_refused(par_refused),
        .power_en(power_en), .usr_wr(usr_wr), .usr_idx(usr_idx), .usr_wdata(usr_wdata),
        .usr_ready(usr_ready), .val_rd(val_rd), .val_idx(val_idx), .val_ready(val_ready),
        .val_rdata(val_rdata), .val_rvalid(val_rvalid), .conv_req(conv_req), .conv_to_usr(conv_to_usr),
        .conv_val(conv_val), .conv_ready(conv_ready), .conv_done(conv_done), .conv_result(conv_result),
        .conv_ovf(conv_ovf), .err_clr(err_clr), .range_err(range_err), .factor_limited(factor_limited),
        .scaled_valid(scaled_valid));
    pus_master_model i_mst (.clk(clk), .par_addr(par_addr), .par_wr(par_wr), .par_rd(par_rd),
        .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rvalid(par_rvalid), .par_refused(par_refused));

    always #12.5 clk = ~clk;

    // A hang is cut short at 6000 cycles, well above the fewer than 2000 cycles the scenarios need.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_count++;
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // Compare and access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic exp_refused);
        logic r;
        i_mst.put(a, d, r);
        chk1(r, exp_refused);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        i_mst.get(a, d);
        chk(d, exp);
    endtask
    task automatic conv(input logic to_usr, input logic [31:0] v, input logic [31:0] exp, input logic ovf);
        int i;
        @(posedge clk);
        conv_req <= 1'b1;
        conv_to_usr <= to_usr;
        conv_val <= v;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (conv_ready !== 1'b1 && i < 900);
        conv_req <= 1'b0;
        conv_val <= ~v;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (conv_done !== 1'b1 && i < 100);
        chk(conv_result, exp);
        chk1(conv_ovf, ovf);
    endtask
    task automatic slot(input logic [3:0] k, input logic [31:0] exp);
        @(posedge clk);
        val_rd <= 1'b1;
        val_idx <= k;
        @(posedge clk);
        val_rd <= 1'b0;
        @(posedge clk);
        chk1(val_rvalid, 1'b1);
        chk(val_rdata, exp);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_defaults;
        rd(PUS_ADDR_DEN, PUS_RST_DEN);
        rd(PUS_ADDR_NUM, PUS_RST_NUM);
        rd(16'h0612, 32'h0);
        chk1(factor_limited, 1'b0);
        conv(1'b0, 32'h64, 32'hC8, 1'b0);
        conv(1'b1, 32'hC8, 32'h64, 1'b0);
        conv(1'b0, 32'hFFFF_FFFD, 32'hFFFF_FFFA, 1'b0);
    endtask
    task automatic s_new_factor;
        wr(PUS_ADDR_DEN, 32'h3, 1'b0);
        conv(1'b0, 32'h64, 32'hC8, 1'b0);
        wr(PUS_ADDR_NUM, 32'h2, 1'b0);
        rd(PUS_ADDR_DEN, 32'h3);
        conv(1'b0, 32'h64, 32'h0021_5555, 1'b0);
        conv(1'b0, 32'hFFFF_FF9C, 32'hFFDE_AAAB, 1'b0);
        conv(1'b1, 32'h0021_5555, 32'h63, 1'b0);
    endtask
    task automatic s_power;
        int i;
        int n_st, n_ft, n_rdy;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            usr_wr <= 1'b1;
            usr_idx <= i[2:0];
            usr_wdata <= 32'h7;
            @(posedge clk);
            usr_wr <= 1'b0;
        end
        power_en <= 1'b1;
        {i, n_st, n_ft, n_rdy} = 128'h0;
        do begin
            @(posedge clk);
            i++;
            n_st  += 32'(!usr_ready);
            n_ft  += 32'(!val_ready);
            n_rdy += 32'(conv_ready);
        end while (scaled_valid !== 1'b1 && i < 1000);
        chk1(scaled_valid, 1'b1);
        chk(n_st, 32'h8);
        chk(n_ft, 32'h8);
        chk(n_rdy, 32'h1);
        slot(4'h8, 32'h0002_5555);
        slot(4'hF, 32'h0002_5555);
        slot(4'h0, 32'h7);
        wr(PUS_ADDR_NUM, 32'h5, 1'b1);
        rd(PUS_ADDR_NUM, 32'h2);
        power_en <= 1'b0;
        repeat (3) @(posedge clk);
        chk1(scaled_valid, 1'b0);
    endtask
    task automatic s_limits;
        wr(PUS_ADDR_NUM, 32'h0, 1'b1);
        wr(PUS_ADDR_DEN, 32'h8000_0000, 1'b1);
        wr(PUS_ADDR_DEN, 32'h0002_0001, 1'b0);
        wr(PUS_ADDR_NUM, 32'h1, 1'b0);
        chk1(factor_limited, 1'b1);
        wr(PUS_ADDR_DEN, 32'h1, 1'b0);
        wr(PUS_ADDR_NUM, PUS_VAL_MAX, 1'b0);
        chk1(factor_limited, 1'b0);
        conv(1'b0, 32'h2, 32'h7FFF_FFFF, 1'b1);
        @(posedge clk);
        chk1(range_err, 1'b1);
        err_clr <= 1'b1;
        @(posedge clk);
        err_clr <= 1'b0;
        @(posedge clk);
        chk1(range_err, 1'b0);
        conv(1'b0, 32'hFFFF_FFFE, 32'h8000_0001, 1'b1);
    endtask

    task automatic conclude;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        {clk, resetn, power_en, usr_wr, val_rd, conv_req, conv_to_usr, err_clr} = 8'h0;
        {usr_idx, val_idx, usr_wdata, conv_val} = 71'h0;
        {err_count, n_compared, cycles} = 96'h0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        s_defaults();
        s_new_factor();
        s_power();
        s_limits();
        conclude();
    end
endmodule

bind pus_top pus_checker i_chk (.clk(clk), .resetn(resetn), .par_addr(par_addr), .par_wr(par_wr),
    .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rvalid(par_rvalid),
    .par_refused(par_refused), .power_en(power_en), .conv_req(conv_req), .conv_ready(conv_ready),
    .conv_done(conv_done), .conv_result(conv_result), .conv_ovf(conv_ovf), .err_clr(err_clr),
    .range_err(range_err), .scaled_valid(scaled_valid));
`default_nettype wire
